// ===== core/jcpa_arbiter.sv
// Test access port to configuration register port bridge with per-transaction arbitration.
`timescale 1ns/100ps
module jcpa_arbiter (
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    input  wire logic                          tck,
    input  wire logic                          tms,
    input  wire logic                          tdi,
    output logic                               tdo,
    output logic                               tdo_oe,
    input  wire logic                          fab_en,
    input  wire logic                          fab_we,
    input  wire logic [jcpa_pkg::JCPA_ADDR_W-1:0] fab_addr,
    input  wire logic [jcpa_pkg::JCPA_DATA_W-1:0] fab_wdata,
    output logic      [jcpa_pkg::JCPA_DATA_W-1:0] fab_rdata,
    output logic                               port_done_strobe,
    output logic                               transfer_pending_flag,
    output logic                               tap_wrote_flag,
    output logic                               ownership_lock_flag,
    input  wire logic                          device_configured,
    output logic                               aux_input_enable,
    output logic                               converter_reset
);
    import jcpa_pkg::*;

    // Test clock domain.
    jcpa_tap_t               tap_ff;
    jcpa_tap_t               nxt_tap;
    logic [JCPA_IR_W-1:0]    ir_sh_ff;
    logic [JCPA_IR_W-1:0]    ir_ff;
    logic [JCPA_CMD_W-1:0]   dr_sh_ff;
    logic [5:0]              cnt_ff;
    logic [JCPA_CMD_W-1:0]   cmd_hold_ff;
    logic                    req_tgl_ff;
    logic                    ack_s1_ff;
    logic                    ack_s2_ff;
    logic                    ack_seen_ff;
    logic [JCPA_DATA_W-1:0]  held_tck_ff;
    logic                    tdo_ff;
    logic                    tdo_oe_ff;

    // Port clock domain.
    jcpa_arb_t               arb_ff;
    logic                    req_s1_ff;
    logic                    req_s2_ff;
    logic                    req_seen_ff;
    logic                    ack_tgl_ff;
    logic [JCPA_DATA_W-1:0]  res_ff;
    logic                    fab_pend_ff;
    logic                    fab_we_ff;
    logic [JCPA_ADDR_W-1:0]  fab_addr_ff;
    logic [JCPA_DATA_W-1:0]  fab_wdata_ff;
    logic [JCPA_DATA_W-1:0]  fab_rdata_ff;
    logic                    done_ff;
    logic                    wrote_ff;
    logic                    lock_ff;
    logic [3:0]              wake_ff;
    logic                    aux_ff;
    logic                    conv_rst_ff;
    logic                    cfg_s1_ff;
    logic                    cfg_s2_ff;
    logic [JCPA_DATA_W-1:0]  cfg_mem [2**JCPA_ADDR_W];

    wire ir_sel     = (ir_ff == JCPA_IR_ACCESS);
    wire in_cap_dr  = (tap_ff == TAP_CAP_DR);
    wire in_sh_dr   = (tap_ff == TAP_SH_DR);
    wire in_upd_dr  = (tap_ff == TAP_UPD_DR);
    wire cmd_full   = (cnt_ff == JCPA_CMD_LEN);
    wire ack_new    = (ack_s2_ff != ack_seen_ff);

    always_comb
    begin
        nxt_tap = tap_ff;
        unique case (tap_ff)
            TAP_RESET:  nxt_tap = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  nxt_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: nxt_tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: nxt_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_tap = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: nxt_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  nxt_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: nxt_tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: nxt_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: nxt_tap = tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tap_ff   <= TAP_RESET;
            ir_sh_ff <= JCPA_IR_BYPASS;
            ir_ff    <= JCPA_IR_BYPASS;
        end
        else
        begin
            tap_ff <= nxt_tap;
            if (tap_ff == TAP_RESET)
                ir_ff <= JCPA_IR_BYPASS;
            else if (tap_ff == TAP_UPD_IR)
                ir_ff <= ir_sh_ff;
            if (tap_ff == TAP_CAP_IR)
                ir_sh_ff <= JCPA_IR_CAPTURE;
            else if (tap_ff == TAP_SH_IR)
                ir_sh_ff <= {tdi, ir_sh_ff[JCPA_IR_W-1:1]};
        end
    end

    // Bypass scans use bit 0 alone, so they are one bit long.
    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dr_sh_ff <= '0;
            cnt_ff   <= '0;
        end
        else if (in_cap_dr)
        begin
            dr_sh_ff <= ir_sel ? {{JCPA_DATA_W{1'b0}}, held_tck_ff} : '0;
            cnt_ff   <= '0;
        end
        else if (in_sh_dr)
        begin
            if (ir_sel)
                dr_sh_ff <= {tdi, dr_sh_ff[JCPA_CMD_W-1:1]};
            else
                dr_sh_ff[0] <= tdi;
            if (cnt_ff != 6'h3F)
                cnt_ff <= cnt_ff + 6'h01;
        end
    end

    // Commands of any other length than a full word are dropped at update.
    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_hold_ff <= '0;
            req_tgl_ff  <= 1'b0;
        end
        else if (in_upd_dr && ir_sel && cmd_full)
        begin
            cmd_hold_ff <= dr_sh_ff;
            req_tgl_ff  <= ~req_tgl_ff;
        end
    end

    // Result arrives from the port domain; until its toggle lands the old word is captured.
    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_s1_ff   <= 1'b0;
            ack_s2_ff   <= 1'b0;
            ack_seen_ff <= 1'b0;
            held_tck_ff <= JCPA_DATA_RST;
        end
        else
        begin
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            if (ack_new)
            begin
                ack_seen_ff <= ack_s2_ff;
                held_tck_ff <= res_ff;
            end
        end
    end

    always_ff @(negedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end
        else
        begin
            tdo_ff    <= (tap_ff == TAP_SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
            tdo_oe_ff <= (tap_ff == TAP_SH_IR) || in_sh_dr;
        end
    end

    assign tdo    = tdo_ff;
    assign tdo_oe = tdo_oe_ff;

    // Port clock domain: the command word is held steady until the next full-length scan reaches Update-DR.
    wire                   tap_req   = (req_s2_ff != req_seen_ff);
    wire                   acc_tap   = (arb_ff == ARB_TAP);
    wire                   acc_fab   = (arb_ff == ARB_FAB);
    wire [JCPA_OP_W-1:0]   tap_op    = cmd_hold_ff[JCPA_OP_LSB +: JCPA_OP_W];
    wire [JCPA_ADDR_W-1:0] tap_addr  = cmd_hold_ff[JCPA_ADDR_LSB +: JCPA_ADDR_W];
    wire [JCPA_DATA_W-1:0] tap_data  = cmd_hold_ff[JCPA_DATA_W-1:0];
    wire                   tap_rd    = acc_tap && (tap_op == JCPA_OP_READ);
    wire                   tap_wr    = acc_tap && (tap_op == JCPA_OP_WRITE);
    wire                   wake_done = (wake_ff == JCPA_WAKE_LAST);
    wire                   fab_ok    = acc_fab && !ownership_lock_flag;
    wire                   fab_rd    = fab_ok && !fab_we_ff;
    wire                   fab_wr    = fab_ok && fab_we_ff;
    wire [JCPA_ADDR_W-1:0] acc_addr  = acc_tap ? tap_addr : fab_addr_ff;
    wire [JCPA_DATA_W-1:0] acc_data  = acc_tap ? tap_data : fab_wdata_ff;
    wire                   is_lock   = (acc_addr == JCPA_REG_LOCK);
    wire                   is_aux    = (acc_addr == JCPA_REG_AUX);
    wire                   is_rst    = (acc_addr == JCPA_REG_RESET);
    wire                   mem_wr    = (tap_wr || fab_wr) && !is_lock && !is_aux && !is_rst;
    wire [JCPA_DATA_W-1:0] rd_word   = (is_lock || is_rst) ? JCPA_DATA_RST : cfg_mem[acc_addr];
    wire                   aux_set   = tap_wr && is_aux && (tap_data == JCPA_AUX_ON)
                                       && !cfg_s2_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            cfg_s1_ff <= 1'b0;
            cfg_s2_ff <= 1'b0;
        end
        else
        begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            cfg_s1_ff <= device_configured;
            cfg_s2_ff <= cfg_s1_ff;
        end
    end

    // Test port wins only when both wait in idle; a running transaction always finishes.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arb_ff      <= ARB_IDLE;
            req_seen_ff <= 1'b0;
        end
        else
        begin
            unique case (arb_ff)
                ARB_IDLE:
                begin
                    if (tap_req)
                    begin
                        arb_ff      <= ARB_TAP;
                        req_seen_ff <= req_s2_ff;
                    end
                    else if (fab_pend_ff)
                        arb_ff <= ARB_FAB;
                end
                ARB_TAP: arb_ff <= ARB_IDLE;
                ARB_FAB: arb_ff <= ARB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fab_pend_ff  <= 1'b0;
            fab_we_ff    <= 1'b0;
            fab_addr_ff  <= '0;
            fab_wdata_ff <= JCPA_DATA_RST;
        end
        else if (fab_en)
        begin
            fab_pend_ff  <= 1'b1;
            fab_we_ff    <= fab_we;
            fab_addr_ff  <= fab_addr;
            fab_wdata_ff <= fab_wdata;
        end
        else if (acc_fab)
            fab_pend_ff <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_ff      <= 1'b0;
            fab_rdata_ff <= JCPA_DATA_RST;
            res_ff       <= JCPA_DATA_RST;
            ack_tgl_ff   <= 1'b0;
        end
        else
        begin
            done_ff <= acc_fab;
            if (acc_fab)
                fab_rdata_ff <= fab_rd ? rd_word : JCPA_DATA_RST;
            if (tap_rd)
                res_ff <= rd_word;
            if (acc_tap)
                ack_tgl_ff <= ~ack_tgl_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (mem_wr)
            cfg_mem[acc_addr] <= acc_data;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrote_ff    <= 1'b0;
            lock_ff     <= 1'b0;
            wake_ff     <= '0;
            aux_ff      <= 1'b0;
            conv_rst_ff <= 1'b0;
        end
        else
        begin
            if (tap_wr)
                wrote_ff <= 1'b1;
            else if (acc_fab)
                wrote_ff <= 1'b0;
            if (tap_wr && is_lock && (tap_data == JCPA_LOCK_ON))
                lock_ff <= 1'b1;
            else if (tap_wr && is_lock && (tap_data == JCPA_LOCK_OFF))
                lock_ff <= 1'b0;
            if (!wake_done)
                wake_ff <= wake_ff + 4'h1;
            if (aux_set)
                aux_ff <= 1'b1;
            conv_rst_ff <= tap_wr && is_rst;
        end
    end

    assign fab_rdata             = fab_rdata_ff;
    assign port_done_strobe      = done_ff;
    assign transfer_pending_flag = tap_req || acc_tap;
    assign tap_wrote_flag        = wrote_ff;
    assign ownership_lock_flag   = lock_ff || !wake_done;
    assign aux_input_enable      = aux_ff;
    assign converter_reset       = conv_rst_ff;

    property p_cmd_len;
        @(posedge tck) disable iff (!reset_n)
        (in_upd_dr && !cmd_full) |=> $stable(req_tgl_ff);
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("short scan issued a command");

    property p_cap_zero;
        @(posedge tck) disable iff (!reset_n)
        (in_cap_dr && ir_sel) |=> (dr_sh_ff == {16'h0000, $past(held_tck_ff)});
    endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("captured word is wrong");

    property p_write_bound;
        @(posedge clk) disable iff (!reset_n)
        $changed(req_s2_ff) |-> ##[0:2] acc_tap;
    endproperty
    a_write_bound: assert property (p_write_bound) else $error("test port access late");

    property p_no_preempt;
        @(posedge clk) disable iff (!reset_n)
        (acc_fab && tap_req) |=> acc_tap == 1'b0 ##1 acc_tap;
    endproperty
    a_no_preempt: assert property (p_no_preempt) else $error("queued access order wrong");

    property p_pending;
        @(posedge clk) disable iff (!reset_n)
        $changed(req_s2_ff) |-> transfer_pending_flag ##1 transfer_pending_flag;
    endproperty
    a_pending: assert property (p_pending) else $error("pending flag dropped early");

    property p_done;
        @(posedge clk) disable iff (!reset_n)
        (fab_en && transfer_pending_flag) |-> !port_done_strobe ##1 !port_done_strobe;
    endproperty
    a_done: assert property (p_done) else $error("done strobe while test port busy");

    property p_nop_hold;
        @(posedge clk) disable iff (!reset_n)
        (acc_tap && tap_op != JCPA_OP_READ) |=> $stable(res_ff);
    endproperty
    a_nop_hold: assert property (p_nop_hold) else $error("held data changed");

    property p_read;
        @(posedge clk) disable iff (!reset_n)
        tap_rd |=> (res_ff == $past(rd_word)) && $changed(ack_tgl_ff);
    endproperty
    a_read: assert property (p_read) else $error("read result not returned");

    property p_wrote;
        @(posedge clk) disable iff (!reset_n)
        tap_wr |=> tap_wrote_flag;
    endproperty
    a_wrote: assert property (p_wrote) else $error("wrote flag not raised");

    property p_lock;
        @(posedge clk) disable iff (!reset_n)
        (acc_fab && ownership_lock_flag) |=> port_done_strobe && (fab_rdata == 16'h0000);
    endproperty
    a_lock: assert property (p_lock) else $error("locked fabric access served");

    property p_wake;
        @(posedge clk) disable iff (!reset_n)
        !wake_done |-> ##[1:9] wake_done;
    endproperty
    a_wake: assert property (p_wake) else $error("lock stays past wake time");

    property p_conv_rst;
        @(posedge clk) disable iff (!reset_n)
        (tap_wr && is_rst) |=> converter_reset ##1 !converter_reset;
    endproperty
    a_conv_rst: assert property (p_conv_rst) else $error("reset pulse wrong");

    c_queued: cover property (@(posedge clk) disable iff (!reset_n) acc_tap && fab_pend_ff ##2 port_done_strobe);
    c_read: cover property (@(posedge clk) disable iff (!reset_n) tap_rd ##[1:40] tap_rd);
    c_lock: cover property (@(posedge clk) disable iff (!reset_n) lock_ff ##1 acc_fab);
endmodule // jcpa_arbiter

// ===== core/jcpa_pkg.sv
// Constants and types shared by the test-port configuration arbiter.
package jcpa_pkg;
    localparam int          JCPA_IR_W          = 6;
    localparam int          JCPA_CMD_W         = 32;
    localparam int          JCPA_DATA_W        = 16;
    localparam int          JCPA_ADDR_W        = 10;
    localparam int          JCPA_OP_W          = 4;
    localparam int          JCPA_ADDR_LSB      = 16;
    localparam int          JCPA_OP_LSB        = 26;
    localparam logic [5:0]  JCPA_IR_ACCESS     = 6'h37;
    localparam logic [5:0]  JCPA_IR_CAPTURE    = 6'h01;
    localparam logic [5:0]  JCPA_IR_BYPASS     = 6'h3F;
    localparam logic [5:0]  JCPA_CMD_LEN       = 6'h20;
    localparam logic [3:0]  JCPA_OP_NOP        = 4'h0;
    localparam logic [3:0]  JCPA_OP_READ       = 4'h1;
    localparam logic [3:0]  JCPA_OP_WRITE      = 4'h2;
    localparam logic [9:0]  JCPA_REG_LOCK      = 10'h000;
    localparam logic [9:0]  JCPA_REG_AUX       = 10'h002;
    localparam logic [9:0]  JCPA_REG_RESET     = 10'h003;
    localparam logic [15:0] JCPA_LOCK_ON       = 16'h0001;
    localparam logic [15:0] JCPA_LOCK_OFF      = 16'h0000;
    localparam logic [15:0] JCPA_AUX_ON        = 16'h0001;
    localparam logic [15:0] JCPA_DATA_RST      = 16'h0000;
    localparam int          JCPA_WRITE_MAX_CYC = 6;
    localparam int          JCPA_LOCK_WAKE_CYC = 10;
    localparam logic [3:0]  JCPA_WAKE_LAST     = 4'(JCPA_LOCK_WAKE_CYC - 1);

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
        TAP_EX2_IR, TAP_UPD_IR
    } jcpa_tap_t;

    typedef enum logic [1:0] {
        ARB_IDLE, ARB_TAP, ARB_FAB
    } jcpa_arb_t;
endpackage

// ===== bench/jcpa_tap_host.sv
// Test access port host model that runs scans and collects the bits shifted out.
`timescale 1ns/100ps
module jcpa_tap_host (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    import jcpa_pkg::*;
    logic at_sel;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        at_sel = 1'b0;
    end
    // One test clock period; the clock stands still between calls.
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24;
        q = tdo;
        tck = 1'b1;
        #24;
        tck = 1'b0;
    endtask
    task automatic go(input logic m);
        logic q;
        tick(m, ~tdi, q);
    endtask
    task automatic shift(input int n, input logic [31:0] v, output logic [31:0] o);
        o = '0;
        for (int i = 0; i < n; i++)
            tick(i == n - 1, v[i], o[i]);
    endtask
    task automatic reset_tap();
        repeat (5) go(1'b1);
        go(1'b0);
        at_sel = 1'b0;
    endtask
    task automatic load_ir();
        logic [31:0] o;
        go(1'b1);
        go(1'b1);
        go(1'b0);
        go(1'b0);
        shift(JCPA_IR_W, 32'(JCPA_IR_ACCESS), o);
        go(1'b1);
        go(1'b0);
    endtask
    // With chain set the next scan follows Update-DR without idle states.
    task automatic scan(input logic [31:0] c, input logic chain, output logic [31:0] o);
        if (!at_sel)
            go(1'b1);
        go(1'b0);
        go(1'b0);
        shift(JCPA_CMD_W, c, o);
        go(1'b1);
        go(chain);
        at_sel = chain;
    endtask
    task automatic idle(input int n);
        repeat (n) go(1'b0);
    endtask
endmodule // jcpa_tap_host

// ===== bench/testbench.sv
// Self-checking bench for the test-port configuration arbiter.
`timescale 1ns/100ps
module testbench;
    import jcpa_pkg::*;
    logic        clk, reset_n, tck, tms, tdi, tdo, fab_en, fab_we, done, pend;
    logic        wrote, lock, dev_cfg, aux, cvt_rst, rst_seen, oe;
    int          oe_cnt = 0;
    logic [9:0]  fab_addr;
    logic [15:0] fab_wdata, fab_rdata, rd;
    logic [31:0] so;
    int          err_total = 0;
    int          cmp_count = 0;
    jcpa_tap_host h (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    jcpa_arbiter dut_u (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(oe), .fab_en(fab_en), .fab_we(fab_we), .fab_addr(fab_addr),
        .fab_wdata(fab_wdata), .fab_rdata(fab_rdata), .port_done_strobe(done),
        .transfer_pending_flag(pend), .tap_wrote_flag(wrote), .ownership_lock_flag(lock),
        .device_configured(dev_cfg), .aux_input_enable(aux), .converter_reset(cvt_rst));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
        if (cvt_rst === 1'b1) rst_seen <= 1'b1;
    // Counts rising test clock edges with the output driven, one per shifted bit.
    always @(posedge tck)
        if (oe === 1'b1) oe_cnt++;
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] cmd(input logic [3:0] op, input logic [9:0] a,
                                        input logic [15:0] d);
        return {2'b00, op, a, d};
    endfunction
    // Next request only after the done strobe of the previous one.
    task automatic fab(input logic we, input logic [9:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        fab_en <= 1'b1;
        fab_we <= we;
        fab_addr <= a;
        fab_wdata <= d;
        @(posedge clk);
        fab_en <= 1'b0;
        for (int i = 0; i < 8 && done !== 1'b1; i++)
            @(posedge clk);
        check(32'(done), 32'h0000_0001);
        q = fab_rdata;
    endtask
    initial
    begin
        {reset_n, fab_en, fab_we, fab_addr, fab_wdata, dev_cfg, rst_seen} = '0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check(32'(lock), 32'h0000_0001);
        repeat (10) @(posedge clk);
        check(32'(lock), 32'h0000_0000);
        h.reset_tap();
        h.load_ir();
        h.scan(cmd(JCPA_OP_WRITE, 10'h010, 16'hA5C3), 1'b0, so);
        h.idle(10);
        check(32'(wrote), 32'h0000_0001);
        fab(1'b1, 10'h011, 16'h1234, rd);
        check(32'(wrote), 32'h0000_0000);
        fab(1'b0, 10'h010, 16'h0000, rd);
        check(32'(rd), 32'h0000_A5C3);
        h.scan(cmd(JCPA_OP_READ, 10'h010, 16'h0000), 1'b0, so);
        h.idle(10);
        h.scan(cmd(JCPA_OP_READ, 10'h011, 16'h0000), 1'b0, so);
        check(so, 32'h0000_A5C3);
        h.idle(10);
        h.scan(cmd(JCPA_OP_NOP, 10'h010, 16'h0000), 1'b0, so);
        check(so, 32'h0000_1234);
        h.idle(10);
        h.scan(cmd(4'hA, 10'h010, 16'h0000), 1'b0, so);
        check(so, 32'h0000_1234);
        h.idle(10);
        h.scan(cmd(JCPA_OP_READ, 10'h010, 16'h0000), 1'b1, so);
        check(so, 32'h0000_1234);
        h.scan(cmd(JCPA_OP_NOP, 10'h000, 16'h0000), 1'b0, so);
        check(so, 32'h0000_1234);
        h.idle(10);
        h.scan(cmd(JCPA_OP_NOP, 10'h000, 16'h0000), 1'b0, so);
        check(so, 32'h0000_A5C3);
        h.scan(cmd(JCPA_OP_WRITE, JCPA_REG_LOCK, JCPA_LOCK_ON), 1'b0, so);
        h.idle(10);
        check(32'(lock), 32'h0000_0001);
        fab(1'b1, 10'h010, 16'hFFFF, rd);
        fab(1'b0, 10'h010, 16'h0000, rd);
        check(32'(rd), 32'h0000_0000);
        h.scan(cmd(JCPA_OP_WRITE, JCPA_REG_LOCK, JCPA_LOCK_OFF), 1'b0, so);
        h.idle(10);
        check(32'(lock), 32'h0000_0000);
        fab(1'b0, 10'h010, 16'h0000, rd);
        check(32'(rd), 32'h0000_A5C3);
        @(posedge clk);
        dev_cfg <= 1'b1;
        h.scan(cmd(JCPA_OP_WRITE, JCPA_REG_AUX, JCPA_AUX_ON), 1'b0, so);
        h.idle(10);
        check(32'(aux), 32'h0000_0000);
        @(posedge clk);
        dev_cfg <= 1'b0;
        h.scan(cmd(JCPA_OP_WRITE, JCPA_REG_AUX, JCPA_AUX_ON), 1'b0, so);
        h.idle(10);
        h.scan(cmd(JCPA_OP_WRITE, JCPA_REG_RESET, 16'h5A5A), 1'b0, so);
        h.idle(10);
        check(32'(aux), 32'h0000_0001);
        check(32'(rst_seen), 32'h0000_0001);
        check(32'(oe_cnt), 32'h0000_01A6);
        end_of_test();
    end
    initial
    begin
        #400000;
        err_total++;
        end_of_test();
    end
endmodule // testbench
